/* common/tsc_pkg.sv */
// Package: register map, field positions and length decode of the transmit control block
package tsc_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] TSC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] TSC_OFS_DATA2  = 8'h04;
  localparam logic [7:0] TSC_OFS_DATA5  = 8'h10;
  localparam logic [7:0] TSC_OFS_AUX    = 8'h14;
  localparam logic [7:0] TSC_OFS_DIV    = 8'h18;
  localparam logic [7:0] TSC_OFS_STATUS = 8'h1C;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int TSC_POS_TE2   = 2;
  localparam int TSC_POS_SHFD  = 6;
  localparam int TSC_POS_TWA   = 7;
  localparam int TSC_POS_MODE  = 8;
  localparam int TSC_POS_SWS   = 10;
  localparam int TSC_POS_ZERO_PAD_CONTROL  = 17;
  localparam int TSC_POS_RSVD  = 18;
  localparam int TSC_POS_SRST  = 8;
  localparam logic [23:0] TSC_CTRL_RESET = 24'h000000;
  localparam logic [4:0]  TSC_DIV_RESET  = 5'h00;
  localparam logic [4:0]  TSC_AC97_DIV   = 5'h0C;
  localparam logic [5:0]  TSC_AC97_SLOT0 = 6'h10;

  // ****************************************
  // Modes
  // ****************************************
  localparam logic [1:0] TSC_MODE_NORMAL = 2'h0;
  localparam logic [1:0] TSC_MODE_NET    = 2'h1;
  localparam logic [1:0] TSC_MODE_AC97   = 2'h3;
  localparam logic [1:0] TSC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TSC_RESP_SLVERR = 2'h2;

  // Slot length in [11:6], word length in [5:0]; reserved codes give 8/8
  function automatic logic [11:0] tsc_len_decode(input logic [4:0] code);
    case (code)
      5'h00: tsc_len_decode = {6'd8, 6'd8};
      5'h04: tsc_len_decode = {6'd12, 6'd8};
      5'h01: tsc_len_decode = {6'd12, 6'd12};
      5'h08: tsc_len_decode = {6'd16, 6'd8};
      5'h05: tsc_len_decode = {6'd16, 6'd12};
      5'h02: tsc_len_decode = {6'd16, 6'd16};
      5'h0C: tsc_len_decode = {6'd20, 6'd8};
      5'h09: tsc_len_decode = {6'd20, 6'd12};
      5'h06: tsc_len_decode = {6'd20, 6'd16};
      5'h03: tsc_len_decode = {6'd20, 6'd20};
      5'h10: tsc_len_decode = {6'd24, 6'd8};
      5'h0D: tsc_len_decode = {6'd24, 6'd12};
      5'h0A: tsc_len_decode = {6'd24, 6'd16};
      5'h07: tsc_len_decode = {6'd24, 6'd20};
      5'h1E: tsc_len_decode = {6'd24, 6'd24};
      5'h18: tsc_len_decode = {6'd32, 6'd8};
      5'h15: tsc_len_decode = {6'd32, 6'd12};
      5'h12: tsc_len_decode = {6'd32, 6'd16};
      5'h0F: tsc_len_decode = {6'd32, 6'd20};
      5'h1F: tsc_len_decode = {6'd32, 6'd24};
      default: tsc_len_decode = {6'd8, 6'd8};
    endcase
  endfunction

endpackage

/* logic/tsc_chan_tx.sv */
// One transmit channel: shift register, arming and slot padding
`timescale 1ns/10ps
`default_nettype none
module tsc_chan_tx
  import tsc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Slot timing
  input  wire logic        tick,
  input  wire logic        frame_start,
  input  wire logic        slot_start,
  input  wire logic        xfer,
  input  wire logic        on_demand,
  input  wire logic [4:0]  bit_idx,
  input  wire logic [5:0]  slot_len,
  input  wire logic [5:0]  word_len,
  // Control and data
  input  wire logic        enable,
  input  wire logic        shfd,
  input  wire logic        tx_word_alignment,
  input  wire logic        zero_pad_control,
  input  wire logic [23:0] data,
  input  wire logic        full,
  // Results
  output logic             load,
  output logic             armed,
  output logic             sdo,
  output logic             oe
);

  typedef struct packed {
    logic [23:0] shift;
    logic        armed;
    logic        sending;
    logic        sdo;
    logic        quit;
  } tsc_chan_type;

  tsc_chan_type st_reg;
  tsc_chan_type st_next;

  always_comb
  begin
    logic [23:0] word;
    logic [5:0]  pad;
    logic [5:0]  k;
    logic [5:0]  bi;
    logic        in_pad;
    word = st_reg.shift;
    pad = slot_len - word_len;
    bi = {1'b0, bit_idx};
    k = 6'h00;
    in_pad = 1'b0;
    st_next = st_reg;
    load = 1'b0;
    // Sticky clear: a clear and re-set inside one word still stops the channel
    if (!enable)
      st_next.quit = 1'b1;
    if (tick)
    begin
      if (frame_start)
      begin
        st_next.armed = enable;
        st_next.quit = 1'b0;
      end
      else if (slot_start && (st_reg.quit || !enable))
        st_next.armed = 1'b0;
      if (slot_start)
      begin
        st_next.sending = 1'b0;
        if (st_next.armed && xfer && (full || !on_demand))
        begin
          load = full;
          st_next.shift = data;
          st_next.sending = 1'b1;
        end
      end
      word = st_next.shift;
      if (!tx_word_alignment)
      begin
        in_pad = bi >= word_len;
        k = in_pad ? word_len - 6'h01 : bi;
      end
      else
      begin
        in_pad = bi < pad;
        k = in_pad ? 6'h00 : bi - pad;
      end
      if (in_pad && zero_pad_control)
        st_next.sdo = 1'b0;
      else if (shfd)
        st_next.sdo = word[k[4:0]];
      else
        st_next.sdo = word[5'(word_len - 6'h01 - k)];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign armed = st_reg.armed;
  assign sdo   = st_reg.sdo;
  assign oe    = st_reg.sending;

endmodule
`default_nettype wire

/* logic/tsc_top.sv */
// Transmit control block: AXI4-Lite registers, slot timing and four channels
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Enable loads data; armed at frame sync
// - Disabled channel finishes word, then stops
// - Shared pin: input or tri-state when off
// - Network re-enable waits for next frame
// - Shift direction: MSB or LSB first
// - Alignment: left or right in slot
// - Left aligned: repeat last or zeros
// - Right aligned: repeat first or zeros
// - Normal mode: one word per frame
// - Network mode: word every slot, but at divider 0 only when data was written
// - Mode field with divider selects framing
// - AC97: 16-bit first slot, twelve 20-bit
// - Short slot length codes decode
// - Slot 24 and 32 codes decode
// - Zero padding control at bit 17
// - Resets clear transmit control register
// - Network divider is words minus one
module tsc_top
  import tsc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial link
  input  wire logic        tx_bit_clk,
  input  wire logic        tx_frame_sync,
  // Shared data pins, index 0 is channel two
  input  wire logic [3:0]  shared_data_pin_i,
  output logic [3:0]       shared_data_pin_o,
  output logic [3:0]       shared_data_pin_oe,
  // Receiver side
  output logic [3:0]       rx_chan_enable,
  output logic [3:0]       rx_serial_data
);

  typedef struct packed {
    logic [23:0]      ctrl;
    logic [3:0][23:0] data;
    logic [3:0]       full;
    logic [3:0]       rx_en;
    logic [4:0]       div;
    logic             aw_ok;
    logic [7:0]       aw_addr;
    logic             w_ok;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [1:0]       clk_sync;
    logic [1:0]       fs_sync;
    logic [3:0]       pin_sync1;
    logic [3:0]       pin_sync2;
    logic [3:0]       rx_data;
    logic             clk_prev;
    logic             fs_prev;
    logic             run;
    logic [4:0]       bit_idx;
    logic [4:0]       slot;
  } tsc_state_type;

  tsc_state_type st_reg;
  tsc_state_type st_next;

  // Channel interface nets
  logic [3:0] ch_load;
  logic [3:0] ch_armed;
  logic [3:0] ch_sdo;
  logic [3:0] ch_oe;
  logic       tick;
  logic       frame_start;
  logic       slot_start;
  logic       xfer;
  logic       on_demand;
  logic [5:0] slot_len;
  logic [5:0] word_len;

  // ****************************************
  // Byte merge for strobed writes
  // ****************************************
  function automatic logic [31:0] tsc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction

  // Slot and word length for a given slot number
  function automatic logic [11:0] tsc_slot_lens(input logic [23:0] ctrl,
                                                input logic [4:0]  div,
                                                input logic [4:0]  slot);
    logic [11:0] r;
    r = tsc_len_decode(ctrl[TSC_POS_SWS +: 5]);
    if (ctrl[TSC_POS_MODE +: 2] == TSC_MODE_AC97 && div == TSC_AC97_DIV && slot == 5'h00)
      r = {TSC_AC97_SLOT0, TSC_AC97_SLOT0};
    return r;
  endfunction

  // ****************************************
  // Register access and link timing
  // ****************************************
  always_comb
  begin
    logic [31:0] cur;
    logic [31:0] merged;
    logic [11:0] lens;
    logic        network;
    logic        mapped;
    int          idx;
    st_next = st_reg;
    cur = 32'h00000000;
    merged = 32'h00000000;
    lens = 12'h000;
    mapped = 1'b1;
    idx = 0;
    network = 1'b0;
    tick = 1'b0;
    frame_start = 1'b0;
    slot_start = 1'b0;
    xfer = 1'b0;
    on_demand = 1'b0;

    // Synchronisers and bit clock edge
    st_next.clk_sync = {st_reg.clk_sync[0], tx_bit_clk};
    st_next.fs_sync = {st_reg.fs_sync[0], tx_frame_sync};
    st_next.pin_sync1 = shared_data_pin_i;
    st_next.pin_sync2 = st_reg.pin_sync1;
    st_next.rx_data = st_reg.pin_sync2 & ~st_reg.ctrl[TSC_POS_TE2 +: 4] // pin c to rx 3-c
                      & {st_reg.rx_en[0], st_reg.rx_en[1], st_reg.rx_en[2], st_reg.rx_en[3]};
    st_next.clk_prev = st_reg.clk_sync[1];
    tick = st_reg.clk_sync[1] && !st_reg.clk_prev;

    // Framing selection
    case (st_reg.ctrl[TSC_POS_MODE +: 2])
      TSC_MODE_NORMAL: network = 1'b0;
      TSC_MODE_NET:    network = 1'b1;
      TSC_MODE_AC97:   network = 1'b1;
      default:         network = 1'b0;
    endcase
    on_demand = st_reg.ctrl[TSC_POS_MODE +: 2] == TSC_MODE_NET && st_reg.div == 5'h00;

    // Slot and frame counters
    if (tick)
    begin
      st_next.fs_prev = st_reg.fs_sync[1];
      lens = tsc_slot_lens(st_reg.ctrl, st_reg.div, st_reg.slot);
      if (st_reg.fs_sync[1] && !st_reg.fs_prev)
      begin
        frame_start = 1'b1;
        slot_start = 1'b1;
        st_next.run = 1'b1;
        st_next.bit_idx = 5'h00;
        st_next.slot = 5'h00;
      end
      else if (st_reg.run)
      begin
        if ({1'b0, st_reg.bit_idx} == lens[11:6] - 6'h01)
        begin
          slot_start = 1'b1;
          st_next.bit_idx = 5'h00;
          st_next.slot = st_reg.slot + 5'h01;
          if (st_reg.slot == st_reg.div)
            st_next.run = 1'b0;
        end
        else
          st_next.bit_idx = st_reg.bit_idx + 5'h01;
      end
      xfer = st_next.run && (network || st_next.slot == 5'h00);
    end
    lens = tsc_slot_lens(st_reg.ctrl, st_reg.div, st_next.slot);
    slot_len = lens[11:6];
    word_len = lens[5:0];

    // Loads empty the holding registers
    st_next.full = st_reg.full & ~ch_load;

    // Write channel
    if (s_axi_awvalid && !st_reg.aw_ok)
    begin
      st_next.aw_ok = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_ok)
    begin
      st_next.w_ok = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.aw_ok && st_reg.w_ok && !st_reg.bvalid)
    begin
      st_next.aw_ok = 1'b0;
      st_next.w_ok = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = TSC_RESP_OKAY;
      case (st_reg.aw_addr)
        TSC_OFS_CTRL:
        begin
          merged = tsc_merge({8'h00, st_reg.ctrl}, st_reg.w_data, st_reg.w_strb);
          st_next.ctrl = merged[23:0];
          st_next.ctrl[TSC_POS_RSVD] = 1'b0;
        end
        TSC_OFS_AUX:
        begin
          merged = tsc_merge({28'h0000000, st_reg.rx_en}, st_reg.w_data, st_reg.w_strb);
          st_next.rx_en = merged[3:0];
          if (merged[TSC_POS_SRST])
            st_next.ctrl = TSC_CTRL_RESET;
        end
        TSC_OFS_DIV:
        begin
          merged = tsc_merge({27'h0000000, st_reg.div}, st_reg.w_data, st_reg.w_strb);
          st_next.div = merged[4:0];
        end
        default:
        begin
          if (st_reg.aw_addr >= TSC_OFS_DATA2 && st_reg.aw_addr <= TSC_OFS_DATA5
              && st_reg.aw_addr[1:0] == 2'h0)
          begin
            idx = int'(st_reg.aw_addr[7:2]) - 1;
            merged = tsc_merge({8'h00, st_reg.data[idx]}, st_reg.w_data, st_reg.w_strb);
            st_next.data[idx] = merged[23:0];
            st_next.full[idx] = 1'b1;
          end
          else
            st_next.bresp = TSC_RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;

    // Read channel
    if (s_axi_arvalid && !st_reg.rvalid)
    begin
      case (s_axi_araddr)
        TSC_OFS_CTRL:   cur = {8'h00, st_reg.ctrl};
        TSC_OFS_AUX:    cur = {28'h0000000, st_reg.rx_en};
        TSC_OFS_DIV:    cur = {27'h0000000, st_reg.div};
        TSC_OFS_STATUS: cur = {26'h0000000, ch_armed,
                               1'b0, ~|(st_reg.full & st_reg.ctrl[TSC_POS_TE2 +: 4])};
        default:
        begin
          if (s_axi_araddr >= TSC_OFS_DATA2 && s_axi_araddr <= TSC_OFS_DATA5
              && s_axi_araddr[1:0] == 2'h0)
            cur = {8'h00, st_reg.data[int'(s_axi_araddr[7:2]) - 1]};
          else
            mapped = 1'b0;
        end
      endcase
      st_next.rvalid = 1'b1;
      st_next.rdata = cur;
      st_next.rresp = mapped ? TSC_RESP_OKAY : TSC_RESP_SLVERR;
    end
    else if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // ****************************************
  // Transmit channels two to five
  // ****************************************
  for (genvar c = 0; c < 4; c++)
  begin : g_chan
    tsc_chan_tx u_chan (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .tick        (tick),
      .frame_start (frame_start),
      .slot_start  (slot_start),
      .xfer        (xfer),
      .on_demand   (on_demand),
      .bit_idx     (st_next.bit_idx),
      .slot_len    (slot_len),
      .word_len    (word_len),
      .enable      (st_reg.ctrl[TSC_POS_TE2 + c]),
      .shfd        (st_reg.ctrl[TSC_POS_SHFD]),
      .tx_word_alignment         (st_reg.ctrl[TSC_POS_TWA]),
      .zero_pad_control        (st_reg.ctrl[TSC_POS_ZERO_PAD_CONTROL]),
      .data        (st_reg.data[c]),
      .full        (st_reg.full[c]),
      .load        (ch_load[c]),
      .armed       (ch_armed[c]),
      .sdo         (ch_sdo[c]),
      .oe          (ch_oe[c])
    );
  end

  // Pin drives only while a word goes out
  assign shared_data_pin_o  = ch_sdo;
  assign shared_data_pin_oe = ch_oe;
  assign rx_chan_enable     = st_reg.rx_en;
  assign rx_serial_data     = st_reg.rx_data;

  assign s_axi_awready = !st_reg.aw_ok;
  assign s_axi_wready  = !st_reg.w_ok;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;

endmodule
`default_nettype wire

/* verification/tsc_top_sva.sv */
// Checker: bus handshake and serial pin assertions of the transmit control block
`timescale 1ns/10ps
`default_nettype none
module tsc_top_sva
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Pins
  input wire logic [3:0]  shared_data_pin_o,
  input wire logic [3:0]  shared_data_pin_oe,
  input wire logic [3:0]  rx_chan_enable,
  input wire logic [3:0]  rx_serial_data
);
  // Receive enable seen from each pin: pin c belongs to receive channel 3-c
  logic [3:0] rx_en_pin;
  assign rx_en_pin = {rx_chan_enable[0], rx_chan_enable[1], rx_chan_enable[2], rx_chan_enable[3]};
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped early");
  chk_ar_gate: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not inverse of rvalid");
  chk_r_delay: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_b_delay: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  chk_reset_idle: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_arready
    && !s_axi_bvalid && !s_axi_rvalid && shared_data_pin_oe == 4'h0)
    else $error("outputs not idle after reset");
  chk_pin_hold: assert property ($changed(shared_data_pin_o) |=>
    $stable(shared_data_pin_o)[*6]) else $error("serial bit too short");
  chk_oe_slot: assert property ($rose(shared_data_pin_oe[0]) |=>
    shared_data_pin_oe[0][*8]) else $error("slot drive too short");
  chk_rx_gate: assert property ((rx_serial_data & ~rx_en_pin
    & ~$past(rx_en_pin)) == 4'h0) else $error("receive data without enable");
  cov_drive0: cover property ($rose(shared_data_pin_oe[0]));
  cov_drive1: cover property ($rose(shared_data_pin_oe[1]));
  cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cov_rx: cover property (|rx_serial_data);
endmodule
bind tsc_top tsc_top_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .shared_data_pin_o, .shared_data_pin_oe, .rx_chan_enable,
  .rx_serial_data);
`default_nettype wire

/* verification/tsc_codec_model.sv */
// Codec model: bit clock and frame sync per frame, captures one data pin
`timescale 1ns/10ps
`default_nettype none
module tsc_codec_model
(
  // Link
  output logic            tx_bit_clk,
  output logic            tx_frame_sync,
  // Observed pins
  input  wire logic [3:0] pin_o,
  input  wire logic [3:0] pin_oe
);
  // ****************************************
  // Frame driver
  // ****************************************
  logic bits[$];
  initial
  begin
    tx_bit_clk = 1'b0;
    tx_frame_sync = 1'b0;
  end
  // Clock runs only inside a frame; sync comes with the first bit
  task automatic run(input int n, input int ch);
    bits.delete();
    #5; // Off the system clock edge
    tx_frame_sync = 1'b1;
    #100;
    repeat (n)
    begin
      tx_bit_clk = 1'b1;
      #200;
      tx_bit_clk = 1'b0;
      tx_frame_sync = 1'b0;
      #190;
      if (pin_oe[ch] === 1'b1)
        bits.push_back(pin_o[ch]);
      #10;
    end
  endtask
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Testbench: registers, framing modes and slot padding against a bit model
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tsc_pkg::*;
  // ****************************************
  // Signals, tasks and sequence
  // ****************************************
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_bit_clk, tx_frame_sync;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
  logic [3:0]  s_axi_wstrb, shared_data_pin_i, shared_data_pin_o, shared_data_pin_oe;
  logic [3:0]  rx_chan_enable, rx_serial_data, ext;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  int          n_mismatch, cmp_count;
  int codes[20] = '{0, 4, 1, 8, 5, 2, 12, 9, 6, 3, 16, 13, 10, 7, 30, 24, 21, 18, 15, 31};
  int sls[20] = '{8, 12, 12, 16, 16, 16, 20, 20, 20, 20, 24, 24, 24, 24, 24, 32, 32, 32, 32, 32};
  int wls[20] = '{8, 8, 12, 8, 12, 16, 8, 12, 16, 20, 8, 12, 16, 20, 24, 8, 12, 16, 20, 24};
  // Wire level of each shared pin
  assign shared_data_pin_i = (shared_data_pin_oe & shared_data_pin_o) | (~shared_data_pin_oe & ext);
  tsc_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .tx_bit_clk, .tx_frame_sync, .shared_data_pin_i, .shared_data_pin_o,
    .shared_data_pin_oe, .rx_chan_enable, .rx_serial_data);
  tsc_codec_model codec (.tx_bit_clk, .tx_frame_sync, .pin_o(shared_data_pin_o),
    .pin_oe(shared_data_pin_oe));
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", nm, exp, seen);
      n_mismatch++;
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 40)
    begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    s_axi_bready <= 1'b0;
    wr_resp = s_axi_bresp;
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    s_axi_rready <= 1'b0;
    rd_val = s_axi_rdata;
    rd_resp = s_axi_rresp;
    tmo(n);
  endtask
  // Expected bit i of a slot
  function automatic logic exp_bit(input logic [23:0] d, input int sl, input int wl,
                                   input int i, input int sh, input int tw, input int pd);
    int k;
    k = (tw != 0) ? i - (sl - wl) : i;
    if (k < 0 || k >= wl)
    begin
      if (pd != 0)
        return 1'b0;
      k = (k < 0) ? 0 : wl - 1;
    end
    return (sh != 0) ? d[k] : d[wl - 1 - k];
  endfunction
  initial
  begin
    int c, k, sh, tw, pd;
    logic [23:0] d;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext} = 52'h0;
    s_axi_wstrb = 4'hF;
    void'($urandom(32'hA8AC));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(TSC_OFS_CTRL);
    chk("ctrl reset", rd_val, 32'h0);
    rd(TSC_OFS_STATUS);
    chk("empty flag", rd_val, 32'h1);
    rd(8'h20);
    chk("unmapped resp", rd_resp, TSC_RESP_SLVERR);
    wr(8'h20, 32'h0);
    chk("unmapped wr resp", wr_resp, TSC_RESP_SLVERR);
    wr(TSC_OFS_CTRL, 32'hFFFFFF);
    chk("ctrl wr resp", wr_resp, TSC_RESP_OKAY);
    rd(TSC_OFS_CTRL);
    chk("ctrl rw", rd_val, 32'hFBFFFF);
    wr(TSC_OFS_AUX, 32'h100);
    rd(TSC_OFS_CTRL);
    chk("soft reset", rd_val, 32'h0);
    repeat (2)
    begin
      d = 24'($urandom % 16);
      wr(TSC_OFS_AUX, d);
      ext <= 4'($urandom);
      repeat (6) @(posedge aclk);
      chk("rx data", rx_serial_data, ext & {d[0], d[1], d[2], d[3]});
      chk("pin oe", shared_data_pin_oe, 32'h0);
      chk("rx enable", rx_chan_enable, d[3:0]);
    end
    wr(TSC_OFS_AUX, 32'h0);
    wr(TSC_OFS_DIV, 32'h1);
    for (c = 0; c < 20; c++)
    begin
      d = 24'($urandom);
      sh = $urandom % 2;
      tw = $urandom % 2;
      pd = $urandom % 2;
      wr(TSC_OFS_DATA2, d);
      wr(TSC_OFS_CTRL, 4 | (sh << 6) | (tw << 7) | (codes[c] << 10) | (pd << 17));
      codec.run(2 * sls[c], 0);
      chk("slot bits", codec.bits.size(), sls[c]);
      for (k = 0; k < sls[c]; k++)
        chk("bit", codec.bits[k], exp_bit(d, sls[c], wls[c], k, sh, tw, pd));
    end
    rd(TSC_OFS_STATUS);
    chk("status after frame", rd_val, 32'h5);
    wr(TSC_OFS_DIV, 32'h0);
    wr(TSC_OFS_CTRL, 32'h104);
    wr(TSC_OFS_DATA2, $urandom);
    codec.run(8, 0);
    chk("demand bits", codec.bits.size(), 8);
    codec.run(8, 0);
    chk("demand idle", codec.bits.size(), 0);
    d = 24'($urandom);
    wr(TSC_OFS_DIV, 32'h2);
    wr(TSC_OFS_DATA2 + 8'h4, d);
    wr(TSC_OFS_CTRL, 32'h108);
    codec.run(24, 1);
    chk("net bits", codec.bits.size(), 24);
    for (k = 0; k < 8; k++)
      chk("net bit", codec.bits[k], exp_bit(d, 8, 8, k, 0, 0, 0));
    fork
      codec.run(24, 1);
      begin
        repeat (30) @(posedge aclk);
        wr(TSC_OFS_CTRL, 32'h100);
        wr(TSC_OFS_CTRL, 32'h108);
      end
    join
    chk("re-enable bits", codec.bits.size(), 8);
    codec.run(24, 1);
    chk("next frame bits", codec.bits.size(), 24);
    wr(TSC_OFS_DIV, TSC_AC97_DIV);
    wr(TSC_OFS_DATA2, $urandom);
    wr(TSC_OFS_CTRL, 32'hF04);
    codec.run(16 + 12 * 20, 0);
    chk("ac97 bits", codec.bits.size(), 256);
    results();
  end
endmodule
`default_nettype wire
